// ---- i2cev_event_flags.sv ----
// Event flags, masking, interrupt, acknowledge handshake and arbitration handling.
`timescale 1ns/100ps
`default_nettype none
module i2cev_event_flags
    import i2cev_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Controller core
    input wire logic core_sda_low_i,
    input wire logic core_scl_low_i,
    input wire logic master_start_i,
    input wire logic master_done_i,
    input wire logic master_stop_req_i,
    input wire logic slave_busy_i,
    input wire logic slave_done_i,
    input wire logic slave_req_i,
    input wire logic expect_cond_i,
    input wire logic tx_fifo_empty_i,
    output logic master_cmd_ready_o,
    output logic slave_notify_o,
    output logic core_abort_o,
    output logic master_retry_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] raw;
        logic [31:0] mask;
        logic [2:0] error_field_a;
        logic [1:0] op;
        i2cev_state_e state;
        logic [31:0] rdata;
        logic irq;
        logic scl_oe_n;
        logic sda_oe_n;
        logic cmd_ready;
        logic slave_notify;
        logic abort;
        logic retry;
    } i2cev_flags_s;

    i2cev_flags_s r;
    i2cev_flags_s next_r;

    logic [1:0] pins_sync;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic bus_busy;

    // ------------------------------------------------------------------
    // Pin synchronisation and line conditions
    // ------------------------------------------------------------------
    i2cev_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_sync)
    );

    i2cev_line_watch u_watch (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .scl_i(pins_sync[1]),
        .sda_i(pins_sync[0]),
        .start_o(start_det),
        .stop_o(stop_det),
        .scl_rise_o(scl_rise),
        .bus_busy_o(bus_busy)
    );

    // Raw view: sticky flags plus the live transmit FIFO empty level.
    function automatic logic [31:0] raw_view(input logic [31:0] flags, input logic tx_empty);
        logic [31:0] v;
        v = flags & I2CEV_STICKY_BITS;
        v[I2CEV_BIT_TX_EMPTY] = tx_empty;
        return v;
    endfunction : raw_view

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] masked;
    logic ack_pending;
    logic arb_lost;
    logic bus_err;
    logic in_transfer;

    always_comb begin
        next_r = r;
        set_bits = '0;
        clr_bits = '0;
        in_transfer = (r.state == I2CEV_ST_MASTER) || slave_busy_i;
        // A bit sent as one that reads back zero means another master won.
        arb_lost = (r.state == I2CEV_ST_MASTER) && scl_rise && !core_sda_low_i
            && !pins_sync[0];
        bus_err = in_transfer && !expect_cond_i && (start_det || stop_det);
        ack_pending = r.raw[I2CEV_BIT_SLAVE_DONE] || r.raw[I2CEV_BIT_NO_STOP]
            || r.raw[I2CEV_BIT_MASTER_DONE];

        set_bits[I2CEV_BIT_SLAVE_DONE] = slave_done_i;
        set_bits[I2CEV_BIT_MASTER_DONE] = master_done_i && master_stop_req_i;
        set_bits[I2CEV_BIT_NO_STOP] = master_done_i && !master_stop_req_i;
        set_bits[I2CEV_BIT_ARB_LOST] = arb_lost;
        set_bits[I2CEV_BIT_BUS_ERROR] = bus_err;

        if (reg_wr_i && reg_addr_i == I2CEV_OFS_CLEAR) begin
            clr_bits = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == I2CEV_OFS_MASK) begin
            next_r.mask = reg_wdata_i;
        end
        // A flag set in the same cycle as its clear stays set.
        next_r.raw = ((r.raw & ~clr_bits) | set_bits) & I2CEV_STICKY_BITS;

        // Status word error_field_a code.
        if (arb_lost) begin
            next_r.error_field_a = I2CEV_ERROR_FIELD_A_ARB_LOST;
            next_r.op = 2'h1;
        end else if (bus_err) begin
            next_r.error_field_a = start_det ? I2CEV_ERROR_FIELD_A_BUS_ERROR_FLAG_START : I2CEV_ERROR_FIELD_A_BUS_ERROR_FLAG_STOP;
            next_r.op = (r.state == I2CEV_ST_MASTER) ? 2'h1 : 2'h2;
        end else if (master_start_i && r.cmd_ready) begin
            next_r.error_field_a = I2CEV_ERROR_FIELD_A_NONE;
            next_r.op = 2'h0;
        end

        // Master arbitration state machine.
        next_r.retry = 1'b0;
        next_r.abort = arb_lost || bus_err;
        unique case (r.state)
            I2CEV_ST_IDLE: begin
                if (master_start_i && r.cmd_ready) begin
                    next_r.state = I2CEV_ST_MASTER;
                end
            end
            I2CEV_ST_MASTER: begin
                if (arb_lost) begin
                    next_r.state = I2CEV_ST_WAIT_STOP;
                end else if (bus_err || master_done_i) begin
                    // A master bus error drops the transfer; the core is aborted.
                    next_r.state = I2CEV_ST_IDLE;
                end
            end
            I2CEV_ST_WAIT_STOP: begin
                if (stop_det || !bus_busy) begin
                    next_r.state = I2CEV_ST_RETRY;
                end
            end
            I2CEV_ST_RETRY: begin
                next_r.retry = 1'b1;
                next_r.state = I2CEV_ST_MASTER;
            end
            default: begin
                next_r.state = I2CEV_ST_IDLE;
            end
        endcase

        // Acknowledge handshake gates commands and slave notices.
        next_r.cmd_ready = !(next_r.raw[I2CEV_BIT_SLAVE_DONE] || next_r.raw[I2CEV_BIT_NO_STOP]
            || next_r.raw[I2CEV_BIT_MASTER_DONE]) && next_r.state == I2CEV_ST_IDLE;
        next_r.slave_notify = slave_req_i && !ack_pending;

        // Clock stretching while a slave-done or no-stop acknowledge is pending, or a master-done one with a slave request.
        next_r.scl_oe_n = !(core_scl_low_i || r.raw[I2CEV_BIT_SLAVE_DONE]
            || r.raw[I2CEV_BIT_NO_STOP]
            || (r.raw[I2CEV_BIT_MASTER_DONE] && slave_req_i));
        // Data line is released after a lost arbitration.
        next_r.sda_oe_n = !(core_sda_low_i && !arb_lost
            && next_r.state != I2CEV_ST_WAIT_STOP);

        masked = raw_view(next_r.raw, tx_fifo_empty_i) & next_r.mask;
        next_r.irq = |masked;

        next_r.rdata = '0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                I2CEV_OFS_RAW: next_r.rdata = raw_view(r.raw, tx_fifo_empty_i);
                I2CEV_OFS_MASKED: begin
                    next_r.rdata = raw_view(r.raw, tx_fifo_empty_i) & r.mask;
                end
                I2CEV_OFS_MASK: next_r.rdata = r.mask;
                I2CEV_OFS_STATUS_WORD: begin
                    next_r.rdata[I2CEV_ERROR_FIELD_A_LSB +: 3] = r.error_field_a;
                    next_r.rdata[I2CEV_OP_LSB +: 2] = r.op;
                end
                default: next_r.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            r.raw <= I2CEV_RESET_WORD;
            r.mask <= I2CEV_RESET_WORD;
            r.error_field_a <= I2CEV_ERROR_FIELD_A_NONE;
            r.op <= 2'h0;
            r.state <= I2CEV_ST_IDLE;
            r.rdata <= '0;
            r.irq <= 1'b0;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
            r.cmd_ready <= 1'b0;
            r.slave_notify <= 1'b0;
            r.abort <= 1'b0;
            r.retry <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_o = r.rdata;
    assign scl_o = 1'b0;
    assign scl_oe_n_o = r.scl_oe_n;
    assign sda_o = 1'b0;
    assign sda_oe_n_o = r.sda_oe_n;
    assign master_cmd_ready_o = r.cmd_ready;
    assign slave_notify_o = r.slave_notify;
    assign core_abort_o = r.abort;
    assign master_retry_o = r.retry;
    assign irq_o = r.irq;

endmodule : i2cev_event_flags
`default_nettype wire

// ---- i2cev_pkg.sv ----
// Package with register map, field positions and state codes of the event status block.
package i2cev_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] I2CEV_OFS_STATUS_WORD = 8'h10;
    localparam logic [7:0] I2CEV_OFS_MASK = 8'h2c;
    localparam logic [7:0] I2CEV_OFS_RAW = 8'h30;
    localparam logic [7:0] I2CEV_OFS_MASKED = 8'h34;
    localparam logic [7:0] I2CEV_OFS_CLEAR = 8'h38;

    // ------------------------------------------------------------------
    // Event bit positions
    // ------------------------------------------------------------------
    localparam int I2CEV_BIT_TX_EMPTY = 0;
    localparam int I2CEV_BIT_MASTER_DONE = 19;
    localparam int I2CEV_BIT_SLAVE_DONE = 20;
    localparam int I2CEV_BIT_ARB_LOST = 24;
    localparam int I2CEV_BIT_BUS_ERROR = 25;
    localparam int I2CEV_BIT_NO_STOP = 28;

    // Bits that hold sticky flags; all others except the live TX_EMPTY bit 0 read as zero.
    localparam logic [31:0] I2CEV_STICKY_BITS = 32'h1318_0000;
    localparam logic [31:0] I2CEV_RESET_WORD = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Error_field_a codes of the status word
    // ------------------------------------------------------------------
    localparam logic [2:0] I2CEV_ERROR_FIELD_A_NONE = 3'h0;
    localparam logic [2:0] I2CEV_ERROR_FIELD_A_ARB_LOST = 3'h1;
    localparam logic [2:0] I2CEV_ERROR_FIELD_A_BUS_ERROR_FLAG_START = 3'h2;
    localparam logic [2:0] I2CEV_ERROR_FIELD_A_BUS_ERROR_FLAG_STOP = 3'h3;
    localparam int I2CEV_ERROR_FIELD_A_LSB = 0;
    localparam int I2CEV_OP_LSB = 4;

    // ------------------------------------------------------------------
    // Master arbitration states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        I2CEV_ST_IDLE = 4'b0001,
        I2CEV_ST_MASTER = 4'b0010,
        I2CEV_ST_WAIT_STOP = 4'b0100,
        I2CEV_ST_RETRY = 4'b1000
    } i2cev_state_e;

endpackage : i2cev_pkg

// ---- i2cev_sync.sv ----
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module i2cev_sync
    import i2cev_pkg::*;
#(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } i2cev_sync_s;

    i2cev_sync_s r;
    i2cev_sync_s next_r;

    always_comb begin
        next_r = r;
        next_r.stage1 = async_i;
        next_r.stage2 = r.stage1;
    end

    // Idle bus lines are high, so the stages reset to one.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign sync_o = r.stage2;

endmodule : i2cev_sync
`default_nettype wire

// ---- i2cev_line_watch.sv ----
// Start, stop and clock edge detection on the synchronised bus lines.
`timescale 1ns/100ps
`default_nettype none
module i2cev_line_watch
    import i2cev_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Synchronised lines
    input wire logic scl_i,
    input wire logic sda_i,
    // Detected conditions
    output logic start_o,
    output logic stop_o,
    output logic scl_rise_o,
    output logic bus_busy_o
);

    typedef struct packed {
        logic scl_d;
        logic sda_d;
        logic busy;
    } i2cev_watch_s;

    i2cev_watch_s r;
    i2cev_watch_s next_r;

    always_comb begin
        next_r = r;
        next_r.scl_d = scl_i;
        next_r.sda_d = sda_i;
        if (start_o) begin
            next_r.busy = 1'b1;
        end else if (stop_o) begin
            next_r.busy = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            r <= '{scl_d: 1'b1, sda_d: 1'b1, busy: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // A data edge while the clock stays high is a start or a stop.
    assign start_o = scl_i && r.scl_d && r.sda_d && !sda_i;
    assign stop_o = scl_i && r.scl_d && !r.sda_d && sda_i;
    assign scl_rise_o = scl_i && !r.scl_d;
    assign bus_busy_o = r.busy;

endmodule : i2cev_line_watch
`default_nettype wire

// ---- i2cev_event_flags_properties.sv ----
// Port-level checks of the event flag block.
`timescale 1ns/100ps
`default_nettype none
module i2cev_flags_checker
    import i2cev_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // Core and outputs
    input wire logic master_done_i,
    input wire logic master_stop_req_i,
    input wire logic slave_done_i,
    input wire logic scl_oe_n_o,
    input wire logic master_cmd_ready_o,
    input wire logic slave_notify_o,
    input wire logic core_abort_o,
    input wire logic master_retry_o,
    input wire logic irq_o
);
    // Mirrors of the slave-done, master-done and no-stop flags and of the mask, rebuilt from the port traffic.
    logic sd_pend, md_pend, ns_pend, abort_seen, clr_wr, hold, blk, slv_irq;
    logic [31:0] mask_q;
    assign clr_wr = reg_wr_i && reg_addr_i == I2CEV_OFS_CLEAR;
    assign hold = sd_pend || ns_pend;
    assign blk = hold || md_pend;
    assign slv_irq = sd_pend && mask_q[I2CEV_BIT_SLAVE_DONE];
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sd_pend <= 1'b0;
            md_pend <= 1'b0;
            ns_pend <= 1'b0;
            abort_seen <= 1'b0;
            mask_q <= 32'h0000_0000;
        end else begin
            sd_pend <= slave_done_i || (sd_pend && !(clr_wr && reg_wdata_i[20]));
            md_pend <= (master_done_i && master_stop_req_i)
                || (md_pend && !(clr_wr && reg_wdata_i[19]));
            ns_pend <= (master_done_i && !master_stop_req_i)
                || (ns_pend && !(clr_wr && reg_wdata_i[28]));
            abort_seen <= core_abort_o || (abort_seen && !master_retry_o);
            if (reg_wr_i && reg_addr_i == I2CEV_OFS_MASK) begin
                mask_q <= reg_wdata_i;
            end
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence s_slave_ack;
        sd_pend && clr_wr && reg_wdata_i[20] && !slave_done_i;
    endsequence
    a_notify_deferred: assert property (hold && $past(hold) |-> !slave_notify_o)
        else $error("Slave notice passed while an acknowledge is pending.");
    a_clock_stretch: assert property (hold && $past(hold) |-> !scl_oe_n_o)
        else $error("Clock line released while an acknowledge is pending.");
    a_command_blocked: assert property (blk && $past(blk) |-> !master_cmd_ready_o)
        else $error("Master command accepted while an acknowledge is pending.");
    a_irq_masked: assert property (mask_q == 32'h0 && $past(mask_q) == 32'h0 |-> !irq_o)
        else $error("Interrupt raised with every event masked.");
    a_irq_slave: assert property (slv_irq && $past(slv_irq) |-> irq_o)
        else $error("Interrupt low with an enabled slave-done flag.");
    a_ack_drops_irq: assert property (s_slave_ack ##0 mask_q == 32'h0010_0000
        |=> !irq_o)
        else $error("Interrupt stayed high after the slave-done clear.");
    a_abort_pulse: assert property (core_abort_o |=> !core_abort_o)
        else $error("Abort pulse longer than one cycle.");
    a_retry_after_abort: assert property (master_retry_o |-> abort_seen)
        else $error("Retry without a preceding abort.");
endmodule : i2cev_flags_checker
bind i2cev_event_flags i2cev_flags_checker u_flags_checker (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .master_done_i(master_done_i), .master_stop_req_i(master_stop_req_i),
    .slave_done_i(slave_done_i), .scl_oe_n_o(scl_oe_n_o), .master_cmd_ready_o(master_cmd_ready_o),
    .slave_notify_o(slave_notify_o), .core_abort_o(core_abort_o),
    .master_retry_o(master_retry_o), .irq_o(irq_o));
`default_nettype wire

// ---- i2cev_bus_peer.sv ----
// Model of the other stations on the two-wire bus.
`timescale 1ns/100ps
`default_nettype none
module i2cev_bus_peer (
    // Design pins
    input wire logic scl_dut_i,
    input wire logic scl_oe_n_i,
    input wire logic sda_dut_i,
    input wire logic sda_oe_n_i,
    // Bench control
    input wire logic run_i,
    input wire logic sda_low_i,
    // Wire levels
    output logic scl_o,
    output logic sda_o
);
    logic scl_low;
    // The peer clock runs at 160 ns inside a frame and stands high outside it.
    initial begin
        scl_low = 1'b0;
        #7;
        forever begin
            #80;
            scl_low = run_i & ~scl_low;
        end
    end
    // Both lines are wired-AND with pull-ups, so any station driving zero wins.
    assign scl_o = (scl_oe_n_i | scl_dut_i) & ~scl_low;
    assign sda_o = (sda_oe_n_i | sda_dut_i) & ~sda_low_i;
endmodule : i2cev_bus_peer
`default_nettype wire

// ---- i2c_event_status_flags_tb.sv ----
// Self-checking bench of the event flag block against a bus peer.
`timescale 1ns/100ps
`default_nettype none
module i2c_event_status_flags_tb;
    import i2cev_pkg::*;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
    logic scl_i, scl_o, scl_oe_n_o, sda_i, sda_o, sda_oe_n_o, run = 1'b0, sda_low = 1'b0;
    logic master_start_i = 1'b0, master_done_i = 1'b0, master_stop_req_i = 1'b0;
    logic slave_busy_i = 1'b0, slave_done_i = 1'b0, slave_req_i = 1'b0;
    logic expect_cond_i = 1'b1, tx_fifo_empty_i = 1'b0, core_sda_low_i = 1'b0;
    logic master_cmd_ready_o, slave_notify_o, core_abort_o, master_retry_o, irq_o;
    int failures = 0, cmp_count = 0, abort_cnt = 0, retry_cnt = 0;
    i2cev_event_flags dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .core_sda_low_i(core_sda_low_i),
        .core_scl_low_i(1'b0), .master_start_i(master_start_i), .master_done_i(master_done_i),
        .master_stop_req_i(master_stop_req_i), .slave_busy_i(slave_busy_i),
        .slave_done_i(slave_done_i), .slave_req_i(slave_req_i), .expect_cond_i(expect_cond_i),
        .tx_fifo_empty_i(tx_fifo_empty_i), .master_cmd_ready_o(master_cmd_ready_o),
        .slave_notify_o(slave_notify_o), .core_abort_o(core_abort_o),
        .master_retry_o(master_retry_o), .irq_o(irq_o));
    i2cev_bus_peer u_peer (.scl_dut_i(scl_o), .scl_oe_n_i(scl_oe_n_o), .sda_dut_i(sda_o),
        .sda_oe_n_i(sda_oe_n_o), .run_i(run), .sda_low_i(sda_low), .scl_o(scl_i), .sda_o(sda_i));
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (core_abort_o === 1'b1) abort_cnt++;
        if (master_retry_o === 1'b1) retry_cnt++;
    end
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask : rd
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk32(v, exp);
    endtask : chk_reg
    task automatic pulse(input int k);
        @(posedge clk_sys_i);
        slave_done_i <= (k == 0);
        master_start_i <= (k == 1);
        master_done_i <= (k == 2);
        @(posedge clk_sys_i);
        slave_done_i <= 1'b0;
        master_start_i <= 1'b0;
        master_done_i <= 1'b0;
    endtask : pulse
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cycles
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
    initial begin
        cycles(20);
        reset_i <= 1'b0;
        chk_reg(I2CEV_OFS_RAW, 32'h0);
        chk_reg(I2CEV_OFS_MASKED, 32'h0);
        chk_reg(I2CEV_OFS_MASK, 32'h0);
        chk_reg(8'hfc, 32'h0);
        wr(I2CEV_OFS_RAW, 32'hffff_ffff);
        chk_reg(I2CEV_OFS_RAW, 32'h0);
        tx_fifo_empty_i <= 1'b1;
        chk_reg(I2CEV_OFS_MASKED, 32'h0);
        wr(I2CEV_OFS_MASK, 32'h1);
        chk_reg(I2CEV_OFS_MASKED, 32'h1);
        chk32(irq_o, 1'b1);
        cycles(1);
        chk32(reg_rdata_o, 32'h0);
        chk32({scl_o, sda_o}, 32'h0);
        tx_fifo_empty_i <= 1'b0;
        chk_reg(I2CEV_OFS_MASKED, 32'h0);
        wr(I2CEV_OFS_MASK, 32'h0010_0000);
        slave_req_i <= 1'b1;
        pulse(0);
        chk_reg(I2CEV_OFS_RAW, 32'h0010_0000);
        chk32({irq_o, scl_oe_n_o, slave_notify_o, master_cmd_ready_o}, 4'h8);
        chk_reg(I2CEV_OFS_STATUS_WORD, 32'h0);
        wr(I2CEV_OFS_CLEAR, 32'hffef_ffff);
        chk_reg(I2CEV_OFS_RAW, 32'h0010_0000);
        wr(I2CEV_OFS_CLEAR, 32'h0010_0000);
        chk_reg(I2CEV_OFS_RAW, 32'h0);
        chk32({irq_o, scl_oe_n_o, slave_notify_o, master_cmd_ready_o}, 4'h7);
        for (int k = 0; k < 2; k++) begin
            master_stop_req_i <= (k == 0);
            pulse(1);
            core_sda_low_i <= 1'b1;
            cycles(3);
            chk32(sda_oe_n_o, 32'h0);
            core_sda_low_i <= 1'b0;
            pulse(2);
            chk_reg(I2CEV_OFS_RAW, (k == 0) ? 32'h0008_0000 : 32'h1000_0000);
            chk32({scl_oe_n_o, slave_notify_o, master_cmd_ready_o}, 3'h0);
            wr(I2CEV_OFS_CLEAR, 32'h1008_0000);
            chk_reg(I2CEV_OFS_RAW, 32'h0);
            chk32({slave_notify_o, master_cmd_ready_o}, 2'h3);
        end
        slave_req_i <= 1'b0;
        slave_busy_i <= 1'b1;
        expect_cond_i <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            sda_low <= (k == 0);
            cycles(8);
            chk_reg(I2CEV_OFS_RAW, 32'h0200_0000);
            rd(I2CEV_OFS_STATUS_WORD, d);
            chk32(d & 32'h37, 32'h20 | (k + 2));
            wr(I2CEV_OFS_CLEAR, 32'h0200_0000);
            chk_reg(I2CEV_OFS_RAW, 32'h0);
        end
        chk32(abort_cnt, 32'd2);
        slave_busy_i <= 1'b0;
        expect_cond_i <= 1'b1;
        pulse(1);
        sda_low <= 1'b1;
        cycles(4);
        run <= 1'b1;
        cycles(40);
        chk_reg(I2CEV_OFS_RAW, 32'h0100_0000);
        rd(I2CEV_OFS_STATUS_WORD, d);
        chk32(d & 32'h37, 32'h11);
        chk32({sda_oe_n_o, abort_cnt[1:0], retry_cnt[0]}, 4'hf - 4'h8 + 4'h8 - 4'h1);
        core_sda_low_i <= 1'b1;
        cycles(2);
        chk32(sda_oe_n_o, 32'h1);
        core_sda_low_i <= 1'b0;
        run <= 1'b0;
        cycles(12);
        sda_low <= 1'b0;
        cycles(12);
        chk32(retry_cnt, 32'd1);
        wr(I2CEV_OFS_CLEAR, 32'h0100_0000);
        chk_reg(I2CEV_OFS_RAW, 32'h0);
        end_of_test();
    end
endmodule : i2c_event_status_flags_tb
`default_nettype wire
